// ==== asf_defs.svh ====
// Constants for the serial frame control block of the sampling converter.
`ifndef ASF_DEFS_SVH
`define ASF_DEFS_SVH

// Frame geometry.
`define ASF_WORD_BITS 16
`define ASF_CNT_W 5
`define ASF_FALL_MUX 5'h02
`define ASF_FALL_RESULT_LATCH 5'h03
`define ASF_FALL_RESULT_MSB 5'h04
`define ASF_FALL_ALARM_CLR 5'h0a
`define ASF_FALL_ALARM_SET 5'h0c
`define ASF_FALL_LAST 5'h10
`define ASF_RISE_ACQ 5'h0e
`define ASF_RISE_LAST 5'h10

// Output word layout.
`define ASF_RES_MSB 11
`define ASF_RES_LSB 2
`define ASF_RES_W 10
`define ASF_CH_W 4

// Command word fields.
`define ASF_CMD_MODE_HI 15
`define ASF_CMD_MODE_LO 12
`define ASF_MODE_MANUAL 4'h1
`define ASF_CMD_PROG 11
`define ASF_CMD_CH_HI 10
`define ASF_CMD_CH_LO 7
`define ASF_CMD_RANGE 6
`define ASF_CMD_PD 5
`define ASF_CMD_RB 4
`define ASF_CMD_GPO_HI 3
`define ASF_CMD_GPO_LO 0

// Reset values.
`define ASF_RST_CH 4'h0
`define ASF_RST_RANGE 1'h0

// Dedicated pin positions, channel count and buffer depth.
`define ASF_PIN_ALM_HI 0
`define ASF_PIN_ALM_LO 1
`define ASF_PIN_RANGE 2
`define ASF_PIN_PD 3
`define ASF_NUM_CH 8
`define ASF_BUF_DEPTH 2

`endif

// ==== asf_frame_ctrl.sv ====
// Frame control of an 8-channel 10-bit converter behind a four-wire serial port.
//
// Operation
// - Chip select falling starts a frame, samples the channel unless powered down, starts conversion.
// - Output word: 4-bit channel address, 10-bit result, then two zero bits, MSB first.
// - When enabled, pin status replaces the channel address field.
// - Multiplexer switches to the new channel on the second serial clock fall.
// - Acquisition runs from fourteenth rising edge to next chip select fall.
// - Four pins, each output, input or dedicated function.
// - Output pins take previous frame's command bits at chip select fall.
// - Input pins captured at chip select fall, sent if readback enabled before.
// - First address bit at chip select fall, rest on falls one to three.
// - Result MSB on fourth fall, LSB on thirteenth fall.
// - Sixteenth fall releases serial output and completes conversion.
// - Command word captured one bit per rising edge from the first.
// - Per-channel high and low thresholds drive alarm pins per configuration.
// - Alarm raised on twelfth fall, cleared on tenth fall of next frame.
// - Soft power-down bit powers down on sixteenth fall of next frame.
// - Power-down pin low powers the device down immediately.
// - Wake on chip select fall if soft bit zero and pin high.
// - Pin zero drives high or combined alarm, pin one low alarm.
// - Range pin high selects wide range, low selects narrow range.
// - Ten-bit results from eight multiplexed channels.
// - Reset gives manual mode with channel zero.
// - Command channel field picks the channel the multiplexer switches to in the next frame, MSB first.
// - Range bit zero selects narrow, one selects wide range.
`timescale 1ns/1ps
`include "asf_defs.svh"

module asf_frame_ctrl (
    // Clock and reset.
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // Serial port.
    input wire logic cs_n_i,
    input wire logic sclk_i,
    input wire logic serial_in_i,
    output logic serial_out_o,
    output logic serial_out_oe_o,
    // Converter front end.
    input wire logic [`ASF_RES_W-1:0] adc_result_i,
    output logic sample_o,
    output logic converting_o,
    output logic acquiring_o,
    output logic [2:0] mux_channel_o,
    output logic wide_range_o,
    output logic powered_down_o,
    // General-purpose pins.
    input wire logic [1:0] pin_mode_i [4],
    input wire logic alarm_combined_i,
    input wire logic [3:0] general_input_i,
    output logic [3:0] general_output_o,
    output logic [3:0] general_output_oe_o,
    // Threshold programming.
    input wire logic thr_wr_i,
    input wire logic [2:0] thr_ch_i,
    input wire logic [`ASF_RES_W-1:0] thr_high_i,
    input wire logic [`ASF_RES_W-1:0] thr_low_i,
    // Received command words.
    output logic [`ASF_WORD_BITS-1:0] cmd_word_o,
    output logic cmd_valid_o,
    input wire logic cmd_ready_i,
    output logic cmd_space_o
);

    ////////////////////////////////////////////////////////////////////////////////
    // Edge detection on the pins, which are synchronous to the clock.

    logic cs_prev_reg;
    logic sclk_prev_reg;
    logic cs_fall;
    logic sclk_fall;
    logic sclk_rise;
    logic [`ASF_CNT_W-1:0] fall_cnt_reg;
    logic [`ASF_CNT_W-1:0] rise_cnt_reg;
    logic [`ASF_CNT_W-1:0] fall_num;
    logic [`ASF_CNT_W-1:0] rise_num;

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            cs_prev_reg <= 1'b1;
            sclk_prev_reg <= 1'b0;
        end else begin
            cs_prev_reg <= cs_n_i;
            sclk_prev_reg <= sclk_i;
        end
    end

    assign cs_fall = cs_prev_reg & ~cs_n_i;
    assign sclk_fall = ~cs_n_i & ~cs_fall & sclk_prev_reg & ~sclk_i;
    assign sclk_rise = ~cs_n_i & ~cs_fall & ~sclk_prev_reg & sclk_i;
    assign fall_num = fall_cnt_reg + `ASF_CNT_W'(1);
    assign rise_num = rise_cnt_reg + `ASF_CNT_W'(1);

    // Counters saturate so that surplus clocks in a long frame do nothing.
    always_ff @(posedge ref_clk_i) begin
        if (rst_i || cs_fall) begin
            fall_cnt_reg <= '0;
            rise_cnt_reg <= '0;
        end else begin
            if (sclk_fall && fall_cnt_reg != `ASF_FALL_LAST) begin
                fall_cnt_reg <= fall_num;
            end
            if (sclk_rise && rise_cnt_reg != `ASF_RISE_LAST) begin
                rise_cnt_reg <= rise_num;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Command word capture and decode.

    logic [`ASF_WORD_BITS-1:0] cmd_sh_reg;
    logic [`ASF_WORD_BITS-1:0] cmd_full;
    logic cmd_done;
    logic [`ASF_CH_W-1:0] next_ch_reg;
    logic range_bit_reg;
    logic soft_pd_reg;
    logic rb_en_reg;
    logic [3:0] gpo_pend_reg;

    assign cmd_full = {cmd_sh_reg[`ASF_WORD_BITS-2:0], serial_in_i};
    assign cmd_done = sclk_rise && rise_num == `ASF_RISE_LAST;

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            cmd_sh_reg <= '0;
        end else if (sclk_rise && rise_cnt_reg != `ASF_RISE_LAST) begin
            cmd_sh_reg <= cmd_full;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            next_ch_reg <= `ASF_RST_CH;
            range_bit_reg <= `ASF_RST_RANGE;
            soft_pd_reg <= 1'b0;
            rb_en_reg <= 1'b0;
            gpo_pend_reg <= '0;
        end else if (cmd_done && cmd_full[`ASF_CMD_MODE_HI:`ASF_CMD_MODE_LO] == `ASF_MODE_MANUAL) begin
            next_ch_reg <= cmd_full[`ASF_CMD_CH_HI:`ASF_CMD_CH_LO];
            // Without the program bit the lower fields keep their last values.
            if (cmd_full[`ASF_CMD_PROG]) begin
                range_bit_reg <= cmd_full[`ASF_CMD_RANGE];
                soft_pd_reg <= cmd_full[`ASF_CMD_PD];
                rb_en_reg <= cmd_full[`ASF_CMD_RB];
                gpo_pend_reg <= cmd_full[`ASF_CMD_GPO_HI:`ASF_CMD_GPO_LO];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Two-entry buffer for received command words.

    logic [`ASF_WORD_BITS-1:0] buf_mem_reg [`ASF_BUF_DEPTH];
    logic buf_wr_ptr_reg;
    logic buf_rd_ptr_reg;
    logic [1:0] buf_cnt_reg;
    logic buf_push;
    logic buf_pop;
    logic [1:0] buf_cnt_next;
    logic buf_rd_ptr_next;

    // A word that finds the buffer full is dropped; cmd_space_o warns the user.
    assign buf_push = cmd_done && buf_cnt_reg != 2'h2;
    assign buf_pop = cmd_valid_o && cmd_ready_i;
    assign buf_cnt_next = buf_cnt_reg + {1'b0, buf_push} - {1'b0, buf_pop};
    assign buf_rd_ptr_next = buf_rd_ptr_reg ^ buf_pop;

    // Flags and head word come from the next state, so they are flops yet never lag.
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            buf_wr_ptr_reg <= 1'b0;
            buf_rd_ptr_reg <= 1'b0;
            buf_cnt_reg <= 2'h0;
            cmd_valid_o <= 1'b0;
            cmd_space_o <= 1'b1;
            cmd_word_o <= '0;
        end else begin
            if (buf_push) begin
                buf_mem_reg[buf_wr_ptr_reg] <= cmd_full;
                buf_wr_ptr_reg <= ~buf_wr_ptr_reg;
            end
            buf_rd_ptr_reg <= buf_rd_ptr_next;
            buf_cnt_reg <= buf_cnt_next;
            cmd_valid_o <= buf_cnt_next != 2'h0;
            cmd_space_o <= buf_cnt_next != 2'h2;
            // A word written into the slot that becomes the head bypasses the memory.
            cmd_word_o <= (buf_push && buf_wr_ptr_reg == buf_rd_ptr_next) ? cmd_full
                : buf_mem_reg[buf_rd_ptr_next];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Frame phases, channel and range.

    logic [`ASF_CH_W-1:0] conv_ch_reg;
    logic [`ASF_RES_W-1:0] result_reg;
    logic pd_pend_reg;

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            sample_o <= 1'b0;
            converting_o <= 1'b0;
            acquiring_o <= 1'b0;
            conv_ch_reg <= `ASF_RST_CH;
            mux_channel_o <= 3'(`ASF_RST_CH);
        end else begin
            sample_o <= cs_fall & ~powered_down_o;
            if (cs_fall) begin
                converting_o <= 1'b1;
                conv_ch_reg <= {1'b0, mux_channel_o};
            end else if (sclk_fall && fall_num == `ASF_FALL_LAST) begin
                converting_o <= 1'b0;
            end
            if (cs_fall) begin
                acquiring_o <= 1'b0;
            end else if (sclk_rise && rise_num == `ASF_RISE_ACQ) begin
                acquiring_o <= 1'b1;
            end
            if (sclk_fall && fall_num == `ASF_FALL_MUX) begin
                mux_channel_o <= next_ch_reg[2:0];
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            result_reg <= '0;
        end else if (sclk_fall && fall_num == `ASF_FALL_RESULT_LATCH) begin
            result_reg <= adc_result_i;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            wide_range_o <= `ASF_RST_RANGE;
        end else if (pin_mode_i[`ASF_PIN_RANGE] == asf_pkg::ASF_PIN_FUNC) begin
            wide_range_o <= general_input_i[`ASF_PIN_RANGE];
        end else if (cs_fall) begin
            wide_range_o <= range_bit_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Power-down.

    logic hw_pd_active;

    assign hw_pd_active = pin_mode_i[`ASF_PIN_PD] == asf_pkg::ASF_PIN_FUNC
        && !general_input_i[`ASF_PIN_PD];

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            pd_pend_reg <= 1'b0;
            powered_down_o <= 1'b0;
        end else begin
            if (cs_fall) begin
                pd_pend_reg <= soft_pd_reg;
            end
            if (hw_pd_active) begin
                powered_down_o <= 1'b1;
            end else if (sclk_fall && fall_num == `ASF_FALL_LAST && pd_pend_reg) begin
                powered_down_o <= 1'b1;
            end else if (cs_fall && !soft_pd_reg) begin
                powered_down_o <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Pin readback and output word.

    logic [3:0] gpi_cap_reg;
    logic use_gpi_reg;
    logic [`ASF_WORD_BITS-1:0] out_word;
    logic [`ASF_CNT_W-1:0] bit_idx;

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            gpi_cap_reg <= '0;
            use_gpi_reg <= 1'b0;
        end else if (cs_fall) begin
            gpi_cap_reg <= general_input_i;
            use_gpi_reg <= rb_en_reg;
        end
    end

    always_comb begin
        out_word = '0;
        if (use_gpi_reg) begin
            out_word[`ASF_WORD_BITS-1:`ASF_RES_MSB+1] = gpi_cap_reg;
        end else begin
            out_word[`ASF_WORD_BITS-1:`ASF_RES_MSB+1] = conv_ch_reg;
        end
        out_word[`ASF_RES_MSB:`ASF_RES_LSB] = result_reg;
    end

    assign bit_idx = `ASF_CNT_W'(`ASF_WORD_BITS - 1) - fall_num;

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            serial_out_o <= 1'b0;
            serial_out_oe_o <= 1'b0;
        end else if (cs_n_i) begin
            serial_out_oe_o <= 1'b0;
        end else if (cs_fall) begin
            serial_out_oe_o <= 1'b1;
            // With only eight channels the address MSB is zero; with readback enabled it is input pin 3 instead.
            serial_out_o <= rb_en_reg & general_input_i[3];
        end else if (sclk_fall) begin
            if (fall_num == `ASF_FALL_LAST) begin
                serial_out_oe_o <= 1'b0;
            end else if (fall_num < `ASF_FALL_LAST) begin
                // address bits on falls one to three, result bits from the fourth fall
                serial_out_o <= out_word[bit_idx[3:0]];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Thresholds and alarms.

    logic [`ASF_RES_W-1:0] thr_high_reg [`ASF_NUM_CH];
    logic [`ASF_RES_W-1:0] thr_low_reg [`ASF_NUM_CH];
    logic alarm_high_reg;
    logic alarm_low_reg;

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < `ASF_NUM_CH; i++) begin
                thr_high_reg[i] <= '1;
                thr_low_reg[i] <= '0;
            end
        end else if (thr_wr_i) begin
            thr_high_reg[thr_ch_i] <= thr_high_i;
            thr_low_reg[thr_ch_i] <= thr_low_i;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            alarm_high_reg <= 1'b0;
            alarm_low_reg <= 1'b0;
        end else if (sclk_fall && fall_num == `ASF_FALL_ALARM_SET) begin
            alarm_high_reg <= result_reg > thr_high_reg[conv_ch_reg[2:0]];
            alarm_low_reg <= result_reg < thr_low_reg[conv_ch_reg[2:0]];
        end else if (sclk_fall && fall_num == `ASF_FALL_ALARM_CLR) begin
            alarm_high_reg <= 1'b0;
            alarm_low_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Pin drivers.

    logic [3:0] gpo_reg;

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            gpo_reg <= '0;
        end else if (cs_fall) begin
            gpo_reg <= gpo_pend_reg;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            general_output_o <= '0;
            general_output_oe_o <= '0;
        end else begin
            for (int p = 0; p < 4; p++) begin
                general_output_o[p] <= gpo_reg[p];
                general_output_oe_o[p] <= pin_mode_i[p] == asf_pkg::ASF_PIN_OUT;
            end
            if (pin_mode_i[`ASF_PIN_ALM_HI] == asf_pkg::ASF_PIN_FUNC) begin
                general_output_o[`ASF_PIN_ALM_HI] <= alarm_high_reg
                    | (alarm_combined_i & alarm_low_reg);
                general_output_oe_o[`ASF_PIN_ALM_HI] <= 1'b1;
            end
            if (pin_mode_i[`ASF_PIN_ALM_LO] == asf_pkg::ASF_PIN_FUNC) begin
                general_output_o[`ASF_PIN_ALM_LO] <= alarm_low_reg;
                general_output_oe_o[`ASF_PIN_ALM_LO] <= 1'b1;
            end
        end
    end

endmodule

// ==== asf_frame_ctrl_asserts.sv ====
// Port-level timing checks for the frame control block.
`timescale 1ns/1ps
`include "asf_defs.svh"

module asf_frame_ctrl_asserts (
    // Clock and reset.
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // Serial port.
    input wire logic cs_n_i,
    input wire logic sclk_i,
    input wire logic serial_out_o,
    input wire logic serial_out_oe_o,
    // Converter status.
    input wire logic sample_o,
    input wire logic converting_o,
    input wire logic acquiring_o,
    input wire logic [2:0] mux_channel_o,
    input wire logic powered_down_o,
    // Pins.
    input wire logic [1:0] pin_mode_i [4],
    input wire logic alarm_combined_i,
    input wire logic [3:0] general_input_i,
    input wire logic [3:0] general_output_o,
    // Command buffer.
    input wire logic [`ASF_WORD_BITS-1:0] cmd_word_o,
    input wire logic cmd_valid_o,
    input wire logic cmd_ready_i,
    input wire logic cmd_space_o
);
    logic cs_q, sclk_q, cs_fall, fall_ev, rise_ev, last_fall, out1, fn0, fn1;
    logic [4:0] fc, rc;

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);

    // The previous chip select resets high, as in the block, so a low level at release counts.
    always_ff @(posedge ref_clk_i) begin
        cs_q <= rst_i | cs_n_i;
        sclk_q <= sclk_i;
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i || cs_fall) begin
            fc <= 5'h00;
            rc <= 5'h00;
        end else begin
            fc <= fc + 5'(fall_ev);
            rc <= rc + 5'(rise_ev);
        end
    end

    assign cs_fall = cs_q & ~cs_n_i;
    assign fall_ev = ~cs_n_i & sclk_q & ~sclk_i;
    assign rise_ev = ~cs_n_i & ~sclk_q & sclk_i;
    assign last_fall = fall_ev & (fc == 5'h0f);
    assign out1 = pin_mode_i[1] == asf_pkg::ASF_PIN_OUT;
    assign fn0 = pin_mode_i[0] == asf_pkg::ASF_PIN_FUNC;
    assign fn1 = pin_mode_i[1] == asf_pkg::ASF_PIN_FUNC;

    ////////////////////////////////////////////////////////////////
    property p_start;
        cs_fall && !powered_down_o |->
            ##[1:2] sample_o && converting_o && serial_out_oe_o && !acquiring_o;
    endproperty
    a_start: assert property (p_start)
        else $error("frame start outputs wrong");
    property p_end;
        last_fall |-> ##[1:2] !serial_out_oe_o && !converting_o;
    endproperty
    a_end: assert property (p_end)
        else $error("output not released after last fall");
    property p_acq;
        $rose(acquiring_o) |-> rc == 5'h0e;
    endproperty
    a_acq: assert property (p_acq)
        else $error("acquisition began on wrong rise");
    property p_mux;
        $changed(mux_channel_o) |-> fc == 5'h02;
    endproperty
    a_mux: assert property (p_mux)
        else $error("channel switched on wrong fall");
    property p_alm_set;
        $rose(general_output_o[1]) && fn1 && $past(fn1, 2) |-> fc == 5'h0c;
    endproperty
    a_alm_set: assert property (p_alm_set)
        else $error("alarm raised on wrong fall");
    property p_alm_clr;
        $fell(general_output_o[0]) && fn0 && $past(fn0, 2) && !alarm_combined_i
            && !$past(alarm_combined_i, 2) |-> fc == 5'h0a;
    endproperty
    a_alm_clr: assert property (p_alm_clr)
        else $error("alarm cleared on wrong fall");
    property p_gpo;
        $changed(general_output_o[1]) && out1 && $past(out1, 2) |->
            $past(cs_fall, 1) || $past(cs_fall, 2);
    endproperty
    a_gpo: assert property (p_gpo)
        else $error("output pin changed away from frame start");
    property p_pd;
        $rose(powered_down_o) |-> $past(last_fall, 1) || $past(last_fall, 2)
            || !$past(general_input_i[3], 1) || !$past(general_input_i[3], 2);
    endproperty
    a_pd: assert property (p_pd)
        else $error("power down at wrong moment");
    property p_hold;
        cmd_valid_o && !cmd_ready_i |=> cmd_valid_o && $stable(cmd_word_o);
    endproperty
    a_hold: assert property (p_hold)
        else $error("buffered command lost while stalled");
    property p_pad;
        (fc == 5'h0e || fc == 5'h0f) && $stable(fc) && serial_out_oe_o |-> !serial_out_o;
    endproperty
    a_pad: assert property (p_pad)
        else $error("trailing result bits not zero");

    c_frame: cover property (cs_fall);
    c_full: cover property (!cmd_space_o);
    c_pd: cover property ($rose(powered_down_o));
endmodule

// ==== asf_frame_ctrl_tb_top.sv ====
// Self-checking bench for the converter frame control.
`timescale 1ns/1ps

module asf_frame_ctrl_tb_top;
    logic clk = 1'h0;
    logic rst = 1'h1;
    logic cs_n, sclk, serial_in, serial_out, oe, smp, conv, acq, wide, pd, cval, crdy, cspc, comb, twr;
    logic [9:0] adc, thi, tlo;
    logic [2:0] mux, tch;
    logic [1:0] pm [4];
    logic [3:0] gin, gout, goe;
    logic [15:0] cw, w;
    logic sdo_line;
    int fail_count = 0;
    int tests_run = 0;

    always #2.5 clk = ~clk;

    asf_frame_ctrl asf_frame_ctrl_i (
        .ref_clk_i(clk), .rst_i(rst), .cs_n_i(cs_n), .sclk_i(sclk), .serial_in_i(serial_in),
        .serial_out_o(serial_out), .serial_out_oe_o(oe), .adc_result_i(adc), .sample_o(smp),
        .converting_o(conv), .acquiring_o(acq), .mux_channel_o(mux), .wide_range_o(wide),
        .powered_down_o(pd), .pin_mode_i(pm), .alarm_combined_i(comb), .general_input_i(gin),
        .general_output_o(gout), .general_output_oe_o(goe), .thr_wr_i(twr), .thr_ch_i(tch),
        .thr_high_i(thi), .thr_low_i(tlo), .cmd_word_o(cw), .cmd_valid_o(cval),
        .cmd_ready_i(crdy), .cmd_space_o(cspc)
    );

    // A released output shows the inverse of its last bit, so a sample taken off-drive shows.
    assign sdo_line = oe ? serial_out : ~serial_out;

    asf_host_model asf_host_model_i (
        .ref_clk_i(clk), .serial_out_i(sdo_line), .cs_n_o(cs_n), .sclk_o(sclk),
        .serial_in_o(serial_in)
    );

    ////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    function automatic logic [15:0] mk(input logic [3:0] ch, input logic [2:0] rpr,
                                       input logic [3:0] general_output);
        return {4'h1, 1'h1, ch, rpr, general_output};
    endfunction

    task automatic fr(input logic [15:0] cmd, input int h);
        asf_host_model_i.frame(cmd, h, w);
    endtask

    task automatic pop(input logic [15:0] exp);
        chk(cw, exp);
        crdy = 1'h1;
        @(negedge clk);
        crdy = 1'h0;
        @(negedge clk);
    endtask

    initial begin
        #200000;
        fail_count++;
        end_of_test();
    end

    ////////////////////////////////////////////////////////////////
    initial begin
        crdy = 1'h0;
        comb = 1'h0;
        twr = 1'h0;
        tch = 3'h0;
        adc = 10'h2a5;
        thi = 10'h200;
        tlo = 10'h100;
        gin = 4'h0;
        pm = '{asf_pkg::ASF_PIN_OUT, asf_pkg::ASF_PIN_OUT, asf_pkg::ASF_PIN_OUT,
               asf_pkg::ASF_PIN_OUT};
        repeat (20) @(negedge clk);
        rst = 1'h0;
        @(negedge clk);
        chk({cspc, wide, pd, mux}, 16'h0020);
        // Buffer stalled: three words arrive, the third finds it full.
        fr(mk(4'h5, 3'h4, 4'ha), 3);
        chk(gout, 4'h0);
        chk(w, {4'h0, 10'h2a5, 2'h0});
        chk({oe, cval, cspc}, 3'h3);
        fr(mk(4'h5, 3'h4, 4'h5), 3);
        chk({mux, wide}, 4'hb);
        chk({goe, gout}, 8'hfa);
        chk(cspc, 1'h0);
        fr(mk(4'h5, 3'h1, 4'h0), 3);
        chk(w[15:12], 4'h5);
        chk(gout, 4'h5);
        pop(mk(4'h5, 3'h4, 4'ha));
        pop(mk(4'h5, 3'h4, 4'h5));
        chk(cval, 1'h0);
        crdy = 1'h1;
        pm = '{asf_pkg::ASF_PIN_IN, asf_pkg::ASF_PIN_IN, asf_pkg::ASF_PIN_IN,
               asf_pkg::ASF_PIN_IN};
        gin = 4'h9;
        fr(mk(4'h5, 3'h0, 4'h0), 3);
        chk(w[15:12], 4'h9);
        chk({goe, wide}, 5'h00);
        pm[2] = asf_pkg::ASF_PIN_FUNC;
        gin = 4'hd;
        repeat (3) @(negedge clk);
        chk(wide, 1'h1);
        gin = 4'h9;
        repeat (3) @(negedge clk);
        chk(wide, 1'h0);
        for (int i = 0; i < 8; i++) begin
            tch = 3'(i);
            twr = 1'h1;
            @(negedge clk);
        end
        twr = 1'h0;
        pm[0] = asf_pkg::ASF_PIN_FUNC;
        pm[1] = asf_pkg::ASF_PIN_FUNC;
        adc = 10'h300;
        fr(mk(4'h5, 3'h0, 4'h0), 3);
        chk(gout[1:0], 2'h1);
        adc = 10'h080;
        fr(mk(4'h5, 3'h0, 4'h0), 3);
        chk(gout[1:0], 2'h2);
        comb = 1'h1;
        repeat (3) @(negedge clk);
        chk(gout[1:0], 2'h3);
        adc = 10'h180;
        fr(mk(4'h5, 3'h2, 4'h0), 6);
        chk(gout[1:0], 2'h0);
        chk(w, {4'h5, 10'h180, 2'h0});
        chk(pd, 1'h0);
        fr(mk(4'h5, 3'h2, 4'h0), 3);
        chk(pd, 1'h1);
        fr(mk(4'h5, 3'h0, 4'h0), 3);
        chk(pd, 1'h1);
        fr(mk(4'h5, 3'h0, 4'h0), 3);
        chk(pd, 1'h0);
        pm[3] = asf_pkg::ASF_PIN_FUNC;
        gin = 4'h1;
        repeat (3) @(negedge clk);
        chk(pd, 1'h1);
        gin = 4'h9;
        fr(mk(4'h5, 3'h0, 4'h0), 3);
        chk(pd, 1'h0);
        end_of_test();
    end
endmodule

bind asf_frame_ctrl asf_frame_ctrl_asserts asf_frame_ctrl_asserts_i (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .cs_n_i(cs_n_i), .sclk_i(sclk_i),
    .serial_out_o(serial_out_o), .serial_out_oe_o(serial_out_oe_o), .sample_o(sample_o),
    .converting_o(converting_o), .acquiring_o(acquiring_o), .mux_channel_o(mux_channel_o),
    .powered_down_o(powered_down_o), .pin_mode_i(pin_mode_i),
    .alarm_combined_i(alarm_combined_i), .general_input_i(general_input_i),
    .general_output_o(general_output_o), .cmd_word_o(cmd_word_o), .cmd_valid_o(cmd_valid_o),
    .cmd_ready_i(cmd_ready_i), .cmd_space_o(cmd_space_o)
);

// ==== asf_host_model.sv ====
// Host serial master that runs whole sixteen-clock frames.
`timescale 1ns/1ps

module asf_host_model (
    // Clock.
    input wire logic ref_clk_i,
    // Serial port.
    input wire logic serial_out_i,
    output logic cs_n_o,
    output logic sclk_o,
    output logic serial_in_o
);
    // The serial clock idles low and stands still between frames.
    initial begin
        cs_n_o = 1'h1;
        sclk_o = 1'h0;
        serial_in_o = 1'h0;
    end

    task automatic frame(input logic [15:0] cmd, input int h, output logic [15:0] word);
        @(negedge ref_clk_i);
        cs_n_o = 1'h0;
        serial_in_o = cmd[15];
        repeat (h) @(negedge ref_clk_i);
        for (int k = 1; k <= 16; k++) begin
            word[16-k] = serial_out_i;
            sclk_o = 1'h1;
            repeat (h) @(negedge ref_clk_i);
            sclk_o = 1'h0;
            if (k < 16) begin
                serial_in_o = cmd[15-k];
            end
            repeat (h) @(negedge ref_clk_i);
        end
        cs_n_o = 1'h1;
        // Data line past its hold time shows a changed level, not the last bit.
        serial_in_o = ~cmd[0];
        repeat (h) @(negedge ref_clk_i);
    endtask
endmodule

// ==== asf_pkg.sv ====
// Types shared by the serial frame control block.
package asf_pkg;
    typedef enum logic [1:0] {
        ASF_PIN_OUT = 2'b00,
        ASF_PIN_IN = 2'b01,
        ASF_PIN_FUNC = 2'b10
    } asf_pin_mode_type;
endpackage
